/* wrpc_ctrl.sv */
// Power control loop of the wireless power receiver
// How it works
// - ADC samples of rectified voltage and current are taken on a periodic tick.
// - Voltage under target asks the transmitter to lower frequency.
// - Voltage over target asks the transmitter to raise frequency.
// - Target voltage falls in steps as regulator load current rises.
// - Dummy load stays on at startup until external load can carry communication.
// - Before regulator enable, the loop drives rectified voltage to 7 V.
// - Regulator enables only in power transfer with rectified voltage at 7 V.
// - Host shutdown turns the regulator off and sends end power transfer.
// - In power transfer, the loop holds voltage at the efficiency target.
// - Full synchronous rectification above 300 mA, half at or below.
// - Switch drivers idle under lockout and until biasing is enabled.
// - Regulator voltage and die temperature feed protection decisions.
// - Foreign object flagged when received power departs from expected power.
// - Volatile option holds exactly one parameter set.
// - Non-volatile option holds up to ten sets picked by profile select.
// - Offset input adds -300 to +300 mW to the expected power.
// - Input above 15 V: regulator off, voltage target set back to 7 V, coils clamped.
// - Clamp switches on above overvoltage, released below its hysteresis.
`timescale 1ns/1ps
module wrpc_ctrl #(
    parameter int SAMPLE_CYC = wrpc_pkg::SAMPLE_CYCLES,
    parameter int SETS = wrpc_pkg::FOD_SETS
) (
    input wire logic clk,
    input wire logic reset,
    input wire wrpc_pkg::wrpc_sample_t adc_sample,
    input wire logic adc_valid,
    output logic adc_start,
    input wire wrpc_pkg::wrpc_cmp_t cmp,
    input wire logic shutdown_req,
    input wire logic id_config_done,
    input wire logic otp_mode,
    input wire logic [15:0] volatile_tol_mw,
    input wire logic [SETS*16-1:0] otp_tol_mw,
    input wire logic [15:0] iset_ma,
    input wire logic [wrpc_pkg::FOD_SEL_W-1:0] fod_profile_select,
    input wire logic signed [15:0] fod_power_offset_select,
    output logic req_valid,
    output wrpc_pkg::wrpc_req_t req_code,
    input wire logic req_ready,
    output logic regulator_enable,
    output logic dummy_load_on,
    output logic sync_full,
    output logic drivers_enable,
    output logic clamp_on,
    output logic coil_input_a_clamp,
    output logic coil_input_b_clamp,
    output logic fault,
    output logic foreign_object
);
    import wrpc_pkg::*;

    initial begin
        if (SAMPLE_CYC < 2) $error("wrpc_ctrl: SAMPLE_CYC too small");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample tick divider

    logic [31:0] tick_cnt_q, tick_cnt_d;
    logic tick;

    // Periodic ADC conversion start
    always_comb begin
        tick = (tick_cnt_q == 32'(SAMPLE_CYC - 1));
        tick_cnt_d = tick ? 32'h0 : tick_cnt_q + 32'h1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) tick_cnt_q <= 32'h0;
        else tick_cnt_q <= tick_cnt_d;
    end

    assign adc_start = tick;

    ////////////////////////////////////////////////////////////////////////////////
    // Captured sample

    wrpc_sample_t smp_q, smp_d;
    logic fresh_q, fresh_d;

    // Latch digitized values for the control logic
    always_comb begin
        smp_d = smp_q;
        fresh_d = 1'b0;
        if (adc_valid) begin
            smp_d = adc_sample;
            fresh_d = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            smp_q <= '0;
            fresh_q <= 1'b0;
        end else begin
            smp_q <= smp_d;
            fresh_q <= fresh_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase machine, regulator and request generation

    wrpc_state_t st_q, st_d;
    logic ldo_q, ldo_d;
    logic pend_q, pend_d;
    wrpc_req_t code_q, code_d;
    logic [15:0] target;
    logic over_vin, prot_fault;
    logic [17:0] i10, i20, i40;

    // Load-dependent target; 7 V until the regulator runs or when input is high
    always_comb begin
        i10 = 18'(iset_ma) / 18'd10;
        i20 = 18'(iset_ma) / 18'd5;
        i40 = (18'(iset_ma) * 18'd2) / 18'd5;
        if (!ldo_q || over_vin) target = RECT_STARTUP_MV;
        else if (18'(smp_q.iout_ma) < i10) target = RECT_STARTUP_MV;
        else if (18'(smp_q.iout_ma) < i20) target = RECT_T1_MV;
        else if (18'(smp_q.iout_ma) < i40) target = RECT_T2_MV;
        else target = RECT_T3_MV;
    end

    // Overvoltage on input and other protection inputs
    always_comb begin
        over_vin = smp_q.vin_mv > VIN_OVER_MV;
        prot_fault = over_vin || !cmp.ldo_ok || !cmp.temp_ok;
    end

    // Phase transitions, regulator enable and pending request
    always_comb begin
        st_d = st_q;
        ldo_d = ldo_q;
        pend_d = pend_q;
        code_d = code_q;
        if (pend_q && req_ready) pend_d = 1'b0;
        case (st_q)
            WRPC_ST_OFF: begin
                ldo_d = 1'b0;
                if (cmp.uvlo_ok && !shutdown_req) st_d = WRPC_ST_PING;
            end
            WRPC_ST_PING: begin
                if (id_config_done) st_d = WRPC_ST_POWER;
                else st_d = WRPC_ST_IDCFG;
            end
            WRPC_ST_IDCFG: begin
                if (id_config_done) st_d = WRPC_ST_POWER;
            end
            WRPC_ST_POWER: begin
                if (!ldo_q && !prot_fault && smp_q.rect_mv >= RECT_STARTUP_MV) begin
                    ldo_d = 1'b1;
                end
                if (prot_fault) ldo_d = 1'b0;
            end
            WRPC_ST_END: begin
                ldo_d = 1'b0;
                if (!shutdown_req && !pend_q) st_d = WRPC_ST_OFF;
            end
            default: st_d = WRPC_ST_OFF;
        endcase
        if (!cmp.uvlo_ok && st_q != WRPC_ST_END) begin
            st_d = WRPC_ST_OFF;
            ldo_d = 1'b0;
        end
        // Shutdown wins over any control request
        if (shutdown_req && st_q != WRPC_ST_END && st_q != WRPC_ST_OFF) begin
            st_d = WRPC_ST_END;
            ldo_d = 1'b0;
            pend_d = 1'b1;
            code_d = WRPC_REQ_END_POWER;
        end else if (fresh_q && !pend_d && (st_q == WRPC_ST_IDCFG || st_q == WRPC_ST_POWER)) begin
            if (smp_q.rect_mv < target) begin
                pend_d = 1'b1;
                code_d = WRPC_REQ_FREQ_DOWN;
            end else if (smp_q.rect_mv > target) begin
                pend_d = 1'b1;
                code_d = WRPC_REQ_FREQ_UP;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= WRPC_ST_OFF;
            ldo_q <= 1'b0;
            pend_q <= 1'b0;
            code_q <= WRPC_REQ_NONE;
        end else begin
            st_q <= st_d;
            ldo_q <= ldo_d;
            pend_q <= pend_d;
            code_q <= code_d;
        end
    end

    assign req_valid = pend_q;
    assign req_code = code_q;
    assign regulator_enable = ldo_q;
    assign fault = prot_fault;

    ////////////////////////////////////////////////////////////////////////////////
    // Rectifier, dummy load and clamps

    logic sync_q, sync_d, drv_q, drv_d, dummy_q, dummy_d, clamp_q, clamp_d, coil_q, coil_d;

    // Rectifier mode, drivers, dummy load, clamp hysteresis
    always_comb begin
        drv_d = cmp.uvlo_ok && cmp.bias_ok;
        sync_d = sync_q;
        if (fresh_q) sync_d = smp_q.irect_ma > SYNC_FULL_MA;
        dummy_d = dummy_q;
        if (st_q == WRPC_ST_OFF) dummy_d = 1'b1;
        else if (fresh_q && ldo_q && smp_q.iout_ma >= DUMMY_RELEASE_MA) dummy_d = 1'b0;
        clamp_d = clamp_q;
        if (cmp.ovp_above) clamp_d = 1'b1;
        else if (cmp.ovp_below_hyst) clamp_d = 1'b0;
        coil_d = over_vin;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync_q <= 1'b0;
            drv_q <= 1'b0;
            dummy_q <= 1'b1;
            clamp_q <= 1'b0;
            coil_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            drv_q <= drv_d;
            dummy_q <= dummy_d;
            clamp_q <= clamp_d;
            coil_q <= coil_d;
        end
    end

    assign sync_full = sync_q && drv_q;
    assign drivers_enable = drv_q;
    assign dummy_load_on = dummy_q;
    assign clamp_on = clamp_q;
    assign coil_input_a_clamp = coil_q;
    assign coil_input_b_clamp = coil_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Foreign object detection

    wrpc_fod #(.SETS(SETS)) u_fod (
        .clk(clk),
        .reset(reset),
        .sample_valid(fresh_q && st_q == WRPC_ST_POWER),
        .power_mw(smp_q.power_mw),
        .expected_mw(16'(({16'h0, smp_q.rect_mv} * {16'h0, smp_q.iout_ma}) / 32'd1000)),
        .otp_mode(otp_mode),
        .volatile_tol_mw(volatile_tol_mw),
        .otp_tol_mw(otp_tol_mw),
        .fod_profile_select(fod_profile_select),
        .fod_power_offset_select(fod_power_offset_select),
        .foreign_object(foreign_object)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence shut_s;
        shutdown_req && st_q != WRPC_ST_END && st_q != WRPC_ST_OFF;
    endsequence

    sequence end_sent_s;
        !regulator_enable && req_valid && req_code == WRPC_REQ_END_POWER;
    endsequence

    shutdown_end_a: assert property (@(posedge clk) disable iff (reset)
        shut_s |=> end_sent_s)
        else $error("shutdown did not raise end request");
    ldo_needs_7v_a: assert property (@(posedge clk) disable iff (reset)
        $rose(regulator_enable) |-> $past(st_q) == WRPC_ST_POWER
            && $past(smp_q.rect_mv) >= RECT_STARTUP_MV)
        else $error("regulator enabled early");
    freq_down_a: assert property (@(posedge clk) disable iff (reset)
        fresh_q && !pend_q && !shutdown_req && st_q == WRPC_ST_POWER && smp_q.rect_mv < target
        |=> req_valid && req_code == WRPC_REQ_FREQ_DOWN)
        else $error("low voltage without lower frequency request");
    freq_up_a: assert property (@(posedge clk) disable iff (reset)
        fresh_q && !pend_q && !shutdown_req && st_q == WRPC_ST_POWER && smp_q.rect_mv > target
        |=> req_valid && req_code == WRPC_REQ_FREQ_UP)
        else $error("high voltage without raise frequency request");
    req_hold_a: assert property (@(posedge clk) disable iff (reset)
        req_valid && !req_ready |=> req_valid && $stable(req_code))
        else $error("request dropped before accept");
    sync_mode_a: assert property (@(posedge clk) disable iff (reset)
        fresh_q && cmp.uvlo_ok && cmp.bias_ok ##1 cmp.uvlo_ok && cmp.bias_ok
        |=> sync_full == ($past(smp_q.irect_ma, 2) > SYNC_FULL_MA))
        else $error("rectifier mode wrong");
    drv_uvlo_a: assert property (@(posedge clk) disable iff (reset)
        !cmp.uvlo_ok |=> !drivers_enable)
        else $error("drivers active under lockout");
    clamp_hyst_a: assert property (@(posedge clk) disable iff (reset)
        clamp_on && !cmp.ovp_below_hyst |=> clamp_on)
        else $error("clamp released above hysteresis");
    ovin_off_a: assert property (@(posedge clk) disable iff (reset)
        over_vin && st_q == WRPC_ST_POWER |=> !regulator_enable ##0 coil_input_a_clamp)
        else $error("input overvoltage not handled");
    target_load_a: assert property (@(posedge clk) disable iff (reset)
        ldo_q && !over_vin && 18'(smp_q.iout_ma) >= i40 |-> target == RECT_T3_MV)
        else $error("heavy load target wrong");
    dummy_start_a: assert property (@(posedge clk) disable iff (reset)
        st_q == WRPC_ST_OFF |=> dummy_load_on)
        else $error("dummy load off at startup");
    prot_inputs_a: assert property (@(posedge clk) disable iff (reset)
        !cmp.temp_ok |-> fault)
        else $error("temperature not in protection");
endmodule // wrpc_ctrl

/* wrpc_pkg.sv */
// Package of constants and carrier types for the wireless receiver power control block
package wrpc_pkg;
    // ADC sample field widths: voltage in mV, current in mA
    localparam int ADC_W = 16;
    // Rectified and input voltage levels in mV
    localparam logic [15:0] RECT_STARTUP_MV = 16'h1b58; // 7000 mV
    localparam logic [15:0] RECT_T1_MV = 16'h189c; // 6300 mV
    localparam logic [15:0] RECT_T2_MV = 16'h157c; // 5500 mV
    localparam logic [15:0] RECT_T3_MV = 16'h154a; // 5450 mV
    localparam logic [15:0] VIN_OVER_MV = 16'h3a98; // 15000 mV
    // Rectifier and load current thresholds in mA
    localparam logic [15:0] SYNC_FULL_MA = 16'h012c; // 300 mA
    localparam logic [15:0] DUMMY_RELEASE_MA = 16'h000f; // external load matching 15 mA dummy
    // FOD offset span in mW
    localparam logic signed [15:0] FOD_OFS_MIN_MW = -16'sd300;
    localparam logic signed [15:0] FOD_OFS_MAX_MW = 16'sd300;
    localparam int FOD_SETS = 10;
    localparam int FOD_SEL_W = 4;
    // Sample period
    localparam int SAMPLE_PERIOD_US = 100;
    localparam int CLK_MHZ = 50;
    localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * CLK_MHZ;

    // Requests handed to the packet transmitter
    typedef enum logic [1:0] {
        WRPC_REQ_NONE = 2'h0,
        WRPC_REQ_FREQ_UP = 2'h1,
        WRPC_REQ_FREQ_DOWN = 2'h2,
        WRPC_REQ_END_POWER = 2'h3
    } wrpc_req_t;

    // One digitized measurement set
    typedef struct packed {
        logic [15:0] rect_mv;
        logic [15:0] irect_ma;
        logic [15:0] iout_ma;
        logic [15:0] vin_mv;
        logic [15:0] power_mw;
    } wrpc_sample_t;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic uvlo_ok;
        logic ovp_above;
        logic ovp_below_hyst;
        logic bias_ok;
        logic ldo_ok;
        logic temp_ok;
    } wrpc_cmp_t;

    // Phases of the receiver
    typedef enum logic [4:0] {
        WRPC_ST_OFF = 5'h01,
        WRPC_ST_PING = 5'h02,
        WRPC_ST_IDCFG = 5'h04,
        WRPC_ST_POWER = 5'h08,
        WRPC_ST_END = 5'h10
    } wrpc_state_t;
endpackage

/* wrpc_fod.sv */
// Foreign object detection check with profile and offset selection
`timescale 1ns/1ps
module wrpc_fod #(
    parameter int SETS = wrpc_pkg::FOD_SETS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic [15:0] power_mw,
    input wire logic [15:0] expected_mw,
    input wire logic otp_mode,
    input wire logic [15:0] volatile_tol_mw,
    input wire logic [SETS*16-1:0] otp_tol_mw,
    input wire logic [wrpc_pkg::FOD_SEL_W-1:0] fod_profile_select,
    input wire logic signed [15:0] fod_power_offset_select,
    output logic foreign_object
);
    import wrpc_pkg::*;

    initial begin
        if (SETS < 1 || SETS > (1 << FOD_SEL_W)) $error("wrpc_fod: bad SETS");
    end

    logic foreign_q, foreign_d;
    logic [15:0] tol;
    logic signed [15:0] ofs;
    logic signed [17:0] ref_mw, diff;

    // Choose tolerance from volatile set or selected non-volatile set, add clamped offset
    always_comb begin
        tol = volatile_tol_mw;
        if (otp_mode) begin
            tol = 16'h0000;
            for (int i = 0; i < SETS; i++) begin
                if (fod_profile_select == i[FOD_SEL_W-1:0]) tol = otp_tol_mw[i*16 +: 16];
            end
        end
        ofs = fod_power_offset_select;
        if (ofs < FOD_OFS_MIN_MW) ofs = FOD_OFS_MIN_MW;
        if (ofs > FOD_OFS_MAX_MW) ofs = FOD_OFS_MAX_MW;
        ref_mw = 18'(signed'({2'b00, expected_mw})) + 18'(ofs);
        diff = 18'(signed'({2'b00, power_mw})) - ref_mw;
        if (diff < 0) diff = -diff;
        foreign_d = foreign_q;
        if (sample_valid) foreign_d = (diff > 18'(signed'({2'b00, tol})));
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) foreign_q <= 1'b0;
        else foreign_q <= foreign_d;
    end

    assign foreign_object = foreign_q;

    fod_update_a: assert property (@(posedge clk) disable iff (reset)
        !sample_valid |=> foreign_object == $past(foreign_object))
        else $error("fod flag changed without sample");
endmodule // wrpc_fod

/* wrpc_tx_model.sv */
// Transmitter model that takes power control requests from the receiver
`timescale 1ns/1ps
module wrpc_tx_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic req_valid,
    input wire wrpc_pkg::wrpc_req_t req_code,
    output logic req_ready,
    output wrpc_pkg::wrpc_req_t last_code,
    output logic [15:0] n_acc
);
    import wrpc_pkg::*;
    int wait_q;
    int seed = 32'h5a17c3e1;
    // One request at a time, accepted after a prompt or a random slow delay
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            req_ready <= 1'b0;
            last_code <= WRPC_REQ_NONE;
            n_acc <= 16'h0000;
            wait_q <= 0;
        end else if (req_ready) begin
            req_ready <= 1'b0;
            last_code <= req_code;
            n_acc <= n_acc + 16'h0001;
            wait_q <= slow ? ($unsigned($random(seed)) % 16) : 0;
        end else if (req_valid) begin
            if (wait_q == 0) begin
                req_ready <= 1'b1;
            end else begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule // wrpc_tx_model

/* wireless_rx_power_control_tb.sv */
// Self-checking bench of the receiver power control block
`timescale 1ns/1ps
module wireless_rx_power_control_tb;
    import wrpc_pkg::*;
    localparam int SC = 10;
    localparam int PER = 12;
    logic clk = 1'b0;
    logic reset = 1'b1;
    wrpc_sample_t smp = '0;
    logic adc_valid = 1'b0;
    wrpc_cmp_t cmp = '0;
    logic shutdown_req = 1'b0;
    logic id_done = 1'b0;
    logic otp_mode = 1'b0;
    logic [15:0] vtol = 16'h0064;
    logic [FOD_SETS*16-1:0] otol = '0;
    logic [15:0] iset = 16'h03e8;
    logic [3:0] psel = 4'h0;
    logic signed [15:0] ofs = 16'sh0000;
    logic slow = 1'b0;
    logic adc_start, req_valid, req_ready, reg_en, dummy, sync_full, drv_en;
    logic clamp_on, ca, cb, fault, fobj;
    wrpc_req_t req_code, last_code;
    logic [15:0] n_acc, n0;
    int n_fail = 0;
    int n_checks = 0;
    int seed = 32'hdc9635f9;
    int n, b, io, vr, ir, tg, k;
    int lo[4] = '{10, 110, 210, 410};
    int ov[4] = '{0, 1000, -300, -1000};

    wrpc_ctrl #(.SAMPLE_CYC(SC)) i_dut (.clk(clk), .reset(reset), .adc_sample(smp),
        .adc_valid(adc_valid), .adc_start(adc_start), .cmp(cmp), .shutdown_req(shutdown_req),
        .id_config_done(id_done), .otp_mode(otp_mode), .volatile_tol_mw(vtol),
        .otp_tol_mw(otol), .iset_ma(iset), .fod_profile_select(psel),
        .fod_power_offset_select(ofs), .req_valid(req_valid), .req_code(req_code),
        .req_ready(req_ready), .regulator_enable(reg_en), .dummy_load_on(dummy),
        .sync_full(sync_full), .drivers_enable(drv_en), .clamp_on(clamp_on),
        .coil_input_a_clamp(ca), .coil_input_b_clamp(cb), .fault(fault),
        .foreign_object(fobj));
    wrpc_tx_model i_tx (.clk(clk), .reset(reset), .slow(slow), .req_valid(req_valid),
        .req_code(req_code), .req_ready(req_ready), .last_code(last_code), .n_acc(n_acc));

    // Clock and an ADC that answers each start pulse one cycle later
    always #10 clk = ~clk;
    always @(posedge clk) adc_valid <= adc_start;

    // Expected rectified voltage target in power transfer for a load current
    function automatic int tgt_of(input int i);
        if (i * 10 < int'(iset)) return 7000;
        if (i * 5 < int'(iset)) return 6300;
        if (i * 10 < int'(iset) * 4) return 5500;
        return 5450;
    endfunction

    // Offset limited to its span
    function automatic int clampo(input int o);
        return (o > 300) ? 300 : ((o < -300) ? -300 : o);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t value %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic put(input int v, input int r, input int o, input int vi, input int pw);
        @(posedge clk);
        smp <= {v[15:0], r[15:0], o[15:0], vi[15:0], pw[15:0]};
    endtask

    task automatic exp_req(input wrpc_req_t c);
        cyc(5 * PER);
        n0 = n_acc;
        cyc(6 * PER);
        check(last_code, c);
        check(n_acc != n0, 1'b1);
    endtask

    task automatic stop_test;
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        cyc(60000);
        n_fail++;
        stop_test;
    end

    // Main sequence
    initial begin
        cyc(16);
        check({reg_en, dummy, req_valid, drv_en, clamp_on, adc_start}, 6'h10);
        reset <= 1'b0;
        cmp <= 6'b100111;
        cyc(3);
        n = 0;
        repeat (10 * SC) begin
            @(posedge clk);
            #1 n += adc_start;
        end
        check(n, 10);
        // Before the regulator is on the target is 7 V whatever the load
        put(6900, 200, 500, 5000, 0);
        exp_req(WRPC_REQ_FREQ_DOWN);
        check({reg_en, dummy}, 2'b01);
        put(7500, 200, 500, 5000, 0);
        exp_req(WRPC_REQ_FREQ_UP);
        check(reg_en, 1'b0);
        // Identification done: power transfer may now start the regulator
        id_done <= 1'b1;
        put(7000, 301, 50, 5000, 350);
        cyc(6 * PER);
        check({reg_en, dummy, drv_en, sync_full}, 4'b1011);
        n0 = n_acc;
        cyc(6 * PER);
        check(n_acc, n0);
        put(7000, 300, 50, 5000, 350);
        cyc(3 * PER);
        check(sync_full, 1'b0);
        // Random loads and voltages around the efficiency target
        for (int i = 0; i < 8; i++) begin
            slow <= i[0];
            b = $unsigned($random(seed)) % 4;
            io = lo[b] + $unsigned($random(seed)) % 80;
            tg = tgt_of(io);
            k = 1 + $unsigned($random(seed)) % 150;
            ir = $unsigned($random(seed)) % 601;
            vr = (k % 2 == 1) ? tg + k : tg - k;
            put(vr, ir, io, 5000, 0);
            exp_req((vr > tg) ? WRPC_REQ_FREQ_UP : WRPC_REQ_FREQ_DOWN);
            check(sync_full, ir > 300);
        end
        // Input overvoltage
        put(7500, 200, 500, 16000, 0);
        exp_req(WRPC_REQ_FREQ_UP);
        check({reg_en, ca, cb, fault}, 4'b0111);
        put(7000, 200, 50, 5000, 350);
        cyc(3 * PER);
        check({ca, cb}, 2'b00);
        // Rectified voltage clamp with hysteresis
        @(posedge clk) cmp <= 6'b110111;
        cyc(3);
        check(clamp_on, 1'b1);
        @(posedge clk) cmp <= 6'b100111;
        cyc(3);
        check(clamp_on, 1'b1);
        @(posedge clk) cmp <= 6'b101111;
        cyc(3);
        check(clamp_on, 1'b0);
        // Profile sets picked by the select input
        cmp <= 6'b100111;
        for (int i = 0; i < FOD_SETS; i++) otol[i*16 +: 16] <= 16'(20 * i + 30);
        otp_mode <= 1'b1;
        for (int i = 0; i < FOD_SETS; i++) begin
            psel <= i[3:0];
            for (int e = 0; e < 2; e++) begin
                put(7000, 200, 1000, 5000, 7000 + 20 * i + 30 + e);
                cyc(3 * PER);
                check(fobj, e);
            end
        end
        // Single volatile set with power offsets
        otp_mode <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            ofs <= 16'(ov[i]);
            for (int e = 0; e < 2; e++) begin
                put(7000, 200, 1000, 5000, 7100 + clampo(ov[i]) + e);
                cyc(3 * PER);
                check(fobj, e);
            end
        end
        // Protection inputs
        put(7000, 200, 50, 5000, 350);
        @(posedge clk) cmp <= 6'b100101;
        cyc(2);
        check(fault, 1'b1);
        @(posedge clk) cmp <= 6'b100110;
        cyc(2);
        check(fault, 1'b1);
        @(posedge clk) cmp <= 6'b100111;
        cyc(6 * PER);
        // Host shutdown
        shutdown_req <= 1'b1;
        k = 0;
        while (k < 300 && last_code !== WRPC_REQ_END_POWER) begin
            @(posedge clk);
            k++;
        end
        check(last_code, WRPC_REQ_END_POWER);
        check(reg_en, 1'b0);
        // Drivers idle under lockout or without bias
        shutdown_req <= 1'b0;
        cmp <= 6'b000111;
        cyc(3 * PER);
        check({drv_en, sync_full}, 2'b00);
        @(posedge clk) cmp <= 6'b100011;
        cyc(6 * PER);
        check(drv_en, 1'b0);
        stop_test;
    end
endmodule // wireless_rx_power_control_tb
